/* File: rtl/rms_baseband.sv */
// baseband end: programs mode over the serial port, drives cycle enable,
// runs raw register access and rebuilds demodulated samples
// assumes a software port on ref_clk; radio pins are re-synchronised
`timescale 1ns/1ps
module rms_baseband #(
  parameter int TX_SETTLE_CYC = rms_pkg::TX_SETTLE_CYC
) (
  input  wire logic                         ref_clk,
  input  wire logic                         rst_n,
  rms_link_if.baseband                      link,
  input  wire logic [7:0]                   addr,
  input  wire logic [31:0]                  wdata,
  input  wire logic                         wr,
  input  wire logic                         rd,
  output logic [31:0]                       rdata,
  output logic [rms_pkg::SAMPLE_W-1:0]      sample_out,
  output logic                              sample_out_valid,
  output logic                              cycle_on
);
  import rms_pkg::*;

  rms_hstate_t st_q;
  logic tx_q, err_q, cyc_q;
  logic [15:0] settle_q;
  logic spi_busy_q;

  wire ctrl_wr  = wr && addr == HOST_CTRL_OFS;
  wire start    = ctrl_wr && wdata[CTRL_START_BIT];
  wire stop     = ctrl_wr && wdata[CTRL_STOP_BIT];
  wire raw_cmd  = wr && addr == HOST_SPI_CMD_OFS;
  wire idle_ok  = st_q == HS_IDLE && !spi_busy_q;
  // commands outside idle would touch the radio mid-cycle or mid-settle
  wire refuse   = ((start || raw_cmd) && !idle_ok) || (stop && st_q != HS_CYCLE);
  wire err_clr  = wr && addr == HOST_STATUS_OFS && wdata[STAT_ERR_BIT];
  wire [6:0] chan = wdata[CTRL_CHAN_LSB +: 7];
  wire high_side = chan <= HIGH_SIDE_MAX_CH;
  logic [15:0] mode_word;
  always_comb begin
    mode_word = 16'h0000;
    mode_word[MODE_TX_BIT]  = wdata[CTRL_TX_BIT];
    mode_word[MODE_RX_BIT]  = !wdata[CTRL_TX_BIT];
    mode_word[MODE_NBW_BIT] = wdata[CTRL_TX_BIT];
    mode_word[MODE_INJ_BIT] = high_side;
  end
  wire        spi_go    = idle_ok && (start || raw_cmd);
  wire [23:0] spi_frame = start ? {1'b0, REG_MODE_IDX, mode_word} : wdata[23:0];

  // serial master, mode 0
  logic       miso_s1_q, miso_s2_q;
  logic [3:0] div_q;
  logic [4:0] bits_q;
  logic [23:0] sh_q, rsh_q;
  logic sclk_q, cs_n_q, mosi_q;
  logic [15:0] spi_rd_q;
  wire half = div_q == 4'(SPI_HALF_CYC - 1);
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      miso_s1_q <= 1'b0;
      miso_s2_q <= 1'b0;
    end else begin
      miso_s1_q <= link.spi_miso;
      miso_s2_q <= miso_s1_q;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      spi_busy_q <= 1'b0;
      div_q      <= 4'h0;
      bits_q     <= 5'd0;
      sh_q       <= 24'h000000;
      rsh_q      <= 24'h000000;
      sclk_q     <= 1'b0;
      cs_n_q     <= 1'b1;
      mosi_q     <= 1'b0;
      spi_rd_q   <= 16'h0000;
    end else if (spi_go) begin
      spi_busy_q <= 1'b1;
      cs_n_q     <= 1'b0;
      mosi_q     <= spi_frame[23];
      sh_q       <= {spi_frame[22:0], 1'b0};
      bits_q     <= 5'd0;
      div_q      <= 4'h0;
    end else if (spi_busy_q) begin
      div_q <= half ? 4'h0 : div_q + 4'h1;
      if (half && !sclk_q) begin
        sclk_q <= 1'b1;
        rsh_q  <= {rsh_q[22:0], miso_s2_q};
        bits_q <= bits_q + 5'd1;
      end else if (half) begin
        sclk_q <= 1'b0;
        if (bits_q == 5'(SPI_FRAME_BITS)) begin
          cs_n_q     <= 1'b1;
          spi_busy_q <= 1'b0;
          spi_rd_q   <= rsh_q[15:0];
        end else begin
          mosi_q <= sh_q[23];
          sh_q   <= {sh_q[22:0], 1'b0};
        end
      end
    end
  end

  // cycle sequencer
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_q     <= HS_IDLE;
      tx_q     <= 1'b0;
      cyc_q    <= 1'b0;
      settle_q <= 16'h0000;
      err_q    <= 1'b0;
    end else begin
      err_q <= refuse | (err_q & ~err_clr);
      case (st_q)
        HS_IDLE:   if (spi_go && start) begin
          st_q <= HS_MODEWR;
          tx_q <= wdata[CTRL_TX_BIT];
        end
        HS_MODEWR: if (!spi_busy_q) begin
          st_q  <= HS_CYCLE;
          cyc_q <= 1'b1;
        end
        HS_CYCLE:  if (stop) begin
          cyc_q    <= 1'b0;
          settle_q <= 16'(TX_SETTLE_CYC);
          st_q     <= tx_q ? HS_SETTLE : HS_IDLE;
        end
        HS_SETTLE: begin
          settle_q <= settle_q - 16'h0001;
          if (settle_q == 16'h0001) st_q <= HS_IDLE;
        end
        default:   st_q <= HS_IDLE;
      endcase
    end
  end

  // sample rebuild from the serial stream
  logic [2:0] rx1_q, rx2_q;
  logic [SAMPLE_W-2:0] dsh_q;
  logic [2:0] dcnt_q;
  logic [SAMPLE_W-1:0] smp_q;
  logic smp_v_q;
  wire [SAMPLE_W-1:0] dnx = {(rx2_q[2] ? {(SAMPLE_W-1){1'b0}} : dsh_q), rx2_q[0]};
  wire [2:0] dcnt_nx = rx2_q[2] ? 3'd1 : dcnt_q + 3'd1;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rx1_q   <= 3'd0;
      rx2_q   <= 3'd0;
      dsh_q   <= '0;
      dcnt_q  <= 3'd0;
      smp_q   <= '0;
      smp_v_q <= 1'b0;
    end else begin
      rx1_q   <= {link.rx_sframe, link.rx_sstrobe, link.rx_sdata};
      rx2_q   <= rx1_q;
      smp_v_q <= 1'b0;
      if (rx2_q[1]) begin
        dsh_q  <= dnx[SAMPLE_W-2:0];
        dcnt_q <= dcnt_nx;
        if (dcnt_nx == 3'(SAMPLE_W)) begin
          smp_q   <= dnx;
          smp_v_q <= 1'b1;
        end
      end
    end
  end

  // software read port, data one cycle after the strobe
  logic [31:0] rdata_q;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) rdata_q <= 32'h00000000;
    else if (rd) begin
      case (addr)
        HOST_SPI_RD_OFS: rdata_q <= {16'h0000, spi_rd_q};
        HOST_STATUS_OFS: rdata_q <= {28'h0000000, err_q, st_q, spi_busy_q};
        HOST_SAMPLE_OFS: rdata_q <= {26'h0000000, smp_q};
        default:         rdata_q <= 32'h00000000;
      endcase
    end else rdata_q <= 32'h00000000;
  end

  assign link.radio_cycle_enable_pin = cyc_q;
  assign link.spi_clk                = sclk_q;
  assign link.spi_cs_n               = cs_n_q;
  assign link.spi_mosi               = mosi_q;
  assign rdata                       = rdata_q;
  assign sample_out                  = smp_q;
  assign sample_out_valid            = smp_v_q;
  assign cycle_on                    = cyc_q;
endmodule : rms_baseband

/* File: rtl/rms_link_if.sv */
// pins between the radio end and the baseband end
// both ends run on ref_clk; every pin is re-synchronised at the receiver
`timescale 1ns/1ps
interface rms_link_if;
  logic radio_cycle_enable_pin;
  logic spi_clk;
  logic spi_cs_n;
  logic spi_mosi;
  logic spi_miso;
  logic rx_sdata;
  logic rx_sstrobe;
  logic rx_sframe;

  modport radio (
    input  radio_cycle_enable_pin,
    input  spi_clk,
    input  spi_cs_n,
    input  spi_mosi,
    output spi_miso,
    output rx_sdata,
    output rx_sstrobe,
    output rx_sframe
  );

  modport baseband (
    output radio_cycle_enable_pin,
    output spi_clk,
    output spi_cs_n,
    output spi_mosi,
    input  spi_miso,
    input  rx_sdata,
    input  rx_sstrobe,
    input  rx_sframe
  );
endinterface : rms_link_if

/* File: rtl/rms_pkg.sv */
// constants and types shared by both ends of the radio mode sequencer link
// assumes a single 40 MHz ref_clk on both ends
package rms_pkg;
  localparam int CLK_MHZ = 40;
  localparam int LNA_ON_US = 150;
  localparam int MIX_ON_US = 150;
  localparam int BPF_ON_US = 10;
  localparam int BPF_TUNE_US = 140;
  localparam int RSSI_UPD_US = 40;
  localparam int TX_SETTLE_US = 20;
  localparam int LNA_ON_CYC = LNA_ON_US * CLK_MHZ;
  localparam int MIX_ON_CYC = MIX_ON_US * CLK_MHZ;
  localparam int BPF_ON_CYC = BPF_ON_US * CLK_MHZ;
  localparam int BPF_TUNE_CYC = BPF_TUNE_US * CLK_MHZ;
  localparam int RSSI_UPD_CYC = RSSI_UPD_US * CLK_MHZ;
  localparam int TX_SETTLE_CYC = TX_SETTLE_US * CLK_MHZ;
  localparam int SER_MBPS = 24;
  localparam int SAMPLE_W = 6;
  localparam int SAMPLES_PER_BIT = 4;
  localparam int RSSI_W = 4;
  // radio register indices and fields, 16-bit words
  localparam logic [6:0] REG_MODE_IDX = 7'h02;
  localparam logic [6:0] REG_RSSI_CTL_IDX = 7'h04;
  localparam logic [6:0] REG_RSSI_RD_IDX = 7'h09;
  localparam logic [6:0] REG_RSSI_VAL_IDX = 7'h1d;
  localparam int MODE_TX_BIT = 14;
  localparam int MODE_RX_BIT = 13;
  localparam int MODE_NBW_BIT = 12;
  localparam int MODE_INJ_BIT = 11;
  localparam int RSSI_EN_BIT = 6;
  localparam int RSSI_RD_BIT = 8;
  localparam int RSSI_VAL_LSB = 0;
  localparam logic [3:0] MODE_RST = 4'h0;
  localparam logic RSSI_EN_RST = 1'b0;
  localparam logic RSSI_RD_RST = 1'b0;
  // serial frame: rw, 7-bit index, 16-bit data, msb first
  localparam int SPI_FRAME_BITS = 24;
  localparam int SPI_HDR_BITS = 8;
  localparam int SPI_HALF_CYC = 8;
  // host register offsets and fields
  localparam logic [7:0] HOST_CTRL_OFS = 8'h00;
  localparam logic [7:0] HOST_SPI_CMD_OFS = 8'h04;
  localparam logic [7:0] HOST_SPI_RD_OFS = 8'h08;
  localparam logic [7:0] HOST_STATUS_OFS = 8'h0c;
  localparam logic [7:0] HOST_SAMPLE_OFS = 8'h10;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_TX_BIT = 1;
  localparam int CTRL_STOP_BIT = 2;
  localparam int CTRL_CHAN_LSB = 8;
  localparam int STAT_ERR_BIT = 3;
  localparam int CH_BASE_MHZ = 2402;
  localparam int HIGH_SIDE_MAX_MHZ = 2441;
  localparam logic [6:0] HIGH_SIDE_MAX_CH = 7'(HIGH_SIDE_MAX_MHZ - CH_BASE_MHZ);

  typedef enum logic [1:0] {
    RMS_IDLE = 2'b00,
    RMS_RX   = 2'b01,
    RMS_TX   = 2'b10
  } rms_mode_t;

  typedef enum logic [1:0] {
    HS_IDLE   = 2'b00,
    HS_MODEWR = 2'b01,
    HS_CYCLE  = 2'b10,
    HS_SETTLE = 2'b11
  } rms_hstate_t;
endpackage : rms_pkg

/* File: rtl/rms_radio.sv */
// radio end: mode registers over serial port, receive-chain sequencing,
// strength capture and the serial demodulated sample stream
// assumes samples arrive on ref_clk; link pins come from the baseband end
`timescale 1ns/1ps
module rms_radio #(
  parameter int LNA_ON_CYC   = rms_pkg::LNA_ON_CYC,
  parameter int MIX_ON_CYC   = rms_pkg::MIX_ON_CYC,
  parameter int BPF_TUNE_CYC = rms_pkg::BPF_TUNE_CYC
) (
  input  wire logic                         ref_clk,
  input  wire logic                         rst_n,
  rms_link_if.radio                         link,
  input  wire logic [rms_pkg::SAMPLE_W-1:0] sample_data,
  input  wire logic                         sample_valid,
  output logic                              sample_ready,
  input  wire logic [rms_pkg::RSSI_W-1:0]   rssi_level,
  output logic                              lna_en,
  output logic                              mixer_en,
  output logic                              bpf_en,
  output logic                              bpf_tuned,
  output logic                              cal_tone_en,
  output logic                              tx_en,
  output logic                              high_side_inj,
  output logic                              power_down,
  output rms_pkg::rms_mode_t                radio_mode,
  output logic [1:0]                        rx_bit_phase
);
  import rms_pkg::*;

  // pin synchronisers: cycle enable, clock, select, data in
  logic [3:0] sy1_q, sy2_q, sy3_q;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sy1_q <= 4'h4;
      sy2_q <= 4'h4;
      sy3_q <= 4'h4;
    end else begin
      sy1_q <= {link.spi_mosi, link.spi_cs_n, link.spi_clk, link.radio_cycle_enable_pin};
      sy2_q <= sy1_q;
      sy3_q <= sy2_q;
    end
  end
  wire cyc_rise  = sy2_q[0] & ~sy3_q[0];
  wire cyc_fall  = ~sy2_q[0] & sy3_q[0];
  wire sclk_rise = sy2_q[1] & ~sy3_q[1];
  wire sclk_fall = ~sy2_q[1] & sy3_q[1];
  wire cs_act    = ~sy2_q[2];
  wire mosi      = sy2_q[3];

  // register state
  logic [3:0] mode_q;  // tx, rx, narrow, injection
  logic rssi_en_q, rssi_rd_q;
  logic [RSSI_W-1:0] rssi_val_q;
  rms_mode_t st_q, st_d;

  function automatic logic [15:0] rd_word(input logic [6:0] idx, input logic [3:0] md,
                                          input logic en, input logic rde,
                                          input logic [RSSI_W-1:0] val, input logic idle);
    logic [15:0] w;
    w = 16'h0000;
    case (idx)
      REG_MODE_IDX:     w[MODE_TX_BIT:MODE_INJ_BIT] = md;
      REG_RSSI_CTL_IDX: w[RSSI_EN_BIT] = en;
      REG_RSSI_RD_IDX:  w[RSSI_RD_BIT] = rde;
      REG_RSSI_VAL_IDX: if (idle && en && rde) w[RSSI_VAL_LSB +: RSSI_W] = val;
      default:          w = 16'h0000;
    endcase
    return w;
  endfunction : rd_word

  // serial register port, mode 0, msb first
  logic [4:0]  bit_cnt_q;
  logic [22:0] sh_in_q;
  logic [15:0] sh_out_q;
  logic        miso_q;
  wire  [23:0] frame_nx = {sh_in_q, mosi};
  wire         hdr_done = sclk_rise && bit_cnt_q == 5'(SPI_HDR_BITS - 1);
  wire         wr_commit = sclk_rise && bit_cnt_q == 5'(SPI_FRAME_BITS - 1) && !frame_nx[23];
  wire  [6:0]  wr_idx = frame_nx[22:16];
  wire  [15:0] wr_dat = frame_nx[15:0];
  wire  [15:0] rd_dat = rd_word(frame_nx[6:0], mode_q, rssi_en_q, rssi_rd_q, rssi_val_q,
                                st_q == RMS_IDLE);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      bit_cnt_q <= 5'h00;
      sh_in_q   <= 23'h000000;
      sh_out_q  <= 16'h0000;
      miso_q    <= 1'b0;
    end else if (!cs_act) begin
      bit_cnt_q <= 5'h00;
      miso_q    <= 1'b0;
    end else begin
      if (sclk_rise) begin
        sh_in_q   <= frame_nx[22:0];
        bit_cnt_q <= bit_cnt_q + 5'h01;
      end
      if (hdr_done) sh_out_q <= frame_nx[7] ? rd_dat : 16'h0000;
      else if (sclk_fall && bit_cnt_q >= 5'(SPI_HDR_BITS)) begin
        miso_q   <= sh_out_q[15];
        sh_out_q <= {sh_out_q[14:0], 1'b0};
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      mode_q    <= MODE_RST;
      rssi_en_q <= RSSI_EN_RST;
      rssi_rd_q <= RSSI_RD_RST;
    end else if (wr_commit) begin
      case (wr_idx)
        REG_MODE_IDX:     mode_q <= wr_dat[MODE_TX_BIT:MODE_INJ_BIT];
        REG_RSSI_CTL_IDX: rssi_en_q <= wr_dat[RSSI_EN_BIT];
        REG_RSSI_RD_IDX:  rssi_rd_q <= wr_dat[RSSI_RD_BIT];
        default:          ;
      endcase
    end
  end

  // mode sequencing; tx bit wins if the host sets both
  wire m_tx = mode_q[MODE_TX_BIT - MODE_INJ_BIT];
  wire m_rx = mode_q[MODE_RX_BIT - MODE_INJ_BIT];
  always_comb begin
    st_d = st_q;
    if (cyc_fall) st_d = RMS_IDLE;
    else if (cyc_rise) st_d = m_tx ? RMS_TX : (m_rx ? RMS_RX : RMS_IDLE);
  end

  localparam int TMR_MAX = (LNA_ON_CYC > BPF_TUNE_CYC) ? LNA_ON_CYC : BPF_TUNE_CYC;
  logic [15:0] tmr_q;
  wire         rx_d = st_d == RMS_RX;
  wire         tmr_sat = tmr_q >= 16'(TMR_MAX);
  logic        lna_q, mix_q, bpf_q, tuned_q, pd_q;

  // enables come from the next state so a fall turns them off at once
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_q    <= RMS_IDLE;
      tmr_q   <= 16'h0000;
      lna_q   <= 1'b0;
      mix_q   <= 1'b0;
      bpf_q   <= 1'b0;
      tuned_q <= 1'b0;
      pd_q    <= 1'b0;
    end else begin
      st_q    <= st_d;
      tmr_q   <= (cyc_rise || !rx_d) ? 16'h0000 : (tmr_sat ? tmr_q : tmr_q + 16'h0001);
      lna_q   <= rx_d && tmr_q >= 16'(LNA_ON_CYC);
      mix_q   <= rx_d && tmr_q >= 16'(MIX_ON_CYC);
      bpf_q   <= rx_d && tmr_q >= 16'(BPF_ON_CYC);
      tuned_q <= rx_d && tmr_q >= 16'(BPF_TUNE_CYC);
      pd_q    <= cyc_fall && st_q != RMS_IDLE;
    end
  end

  // two-entry sample buffer; flushed outside receive
  logic [SAMPLE_W-1:0] buf_q [2];
  logic       wp_q, rp_q;
  logic [1:0] cnt_q;
  logic       ser_pop;
  wire        in_rx = st_q == RMS_RX;
  assign sample_ready = in_rx && cnt_q != 2'd2;
  wire        push = sample_valid && sample_ready;
  wire        pop  = ser_pop && cnt_q != 2'd0;
  always_ff @(posedge ref_clk) begin
    if (!rst_n || !in_rx) begin
      wp_q  <= 1'b0;
      rp_q  <= 1'b0;
      cnt_q <= 2'd0;
    end else begin
      if (push) begin
        buf_q[wp_q] <= sample_data;
        wp_q        <= ~wp_q;
      end
      if (pop) rp_q <= ~rp_q;
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  // bit pacing: 24 of every 40 clocks carry a bit
  logic [5:0] acc_q;
  wire  [6:0] acc_sum = {1'b0, acc_q} + 7'(SER_MBPS);
  wire        bit_stb = acc_sum >= 7'(CLK_MHZ);
  logic [SAMPLE_W-1:0] sh_q;
  logic [2:0] left_q;
  logic       sd_q, ss_q, sf_q;
  logic [1:0] ph_q;
  assign ser_pop = bit_stb && left_q == 3'd0;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      acc_q  <= 6'h00;
      sh_q   <= '0;
      left_q <= 3'd0;
      sd_q   <= 1'b0;
      ss_q   <= 1'b0;
      sf_q   <= 1'b0;
      ph_q   <= 2'd0;
    end else begin
      acc_q <= bit_stb ? 6'(acc_sum - 7'(CLK_MHZ)) : acc_sum[5:0];
      ss_q  <= 1'b0;
      sf_q  <= 1'b0;
      if (!in_rx) begin
        left_q <= 3'd0;
        ph_q   <= 2'd0;
        sd_q   <= 1'b0;
      end else if (pop) begin
        sd_q   <= buf_q[rp_q][SAMPLE_W-1];
        sh_q   <= {buf_q[rp_q][SAMPLE_W-2:0], 1'b0};
        left_q <= 3'(SAMPLE_W - 1);
        ss_q   <= 1'b1;
        sf_q   <= 1'b1;
        ph_q   <= 2'(ph_q + 2'd1);
      end else if (bit_stb && left_q != 3'd0) begin
        sd_q   <= sh_q[SAMPLE_W-1];
        sh_q   <= {sh_q[SAMPLE_W-2:0], 1'b0};
        left_q <= left_q - 3'd1;
        ss_q   <= 1'b1;
      end
    end
  end

  // strength capture 40 us after the first sample of the cycle
  logic        seen_q;
  logic [10:0] rtmr_q;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      seen_q     <= 1'b0;
      rtmr_q     <= 11'd0;
      rssi_val_q <= '0;
    end else if (!in_rx) begin
      seen_q <= 1'b0;
      rtmr_q <= 11'd0;
    end else begin
      if (push) seen_q <= 1'b1;
      if (seen_q && rtmr_q != 11'(RSSI_UPD_CYC)) rtmr_q <= rtmr_q + 11'd1;
      if (seen_q && rtmr_q == 11'(RSSI_UPD_CYC - 1) && rssi_en_q) rssi_val_q <= rssi_level;
    end
  end

  assign link.spi_miso   = miso_q;
  assign link.rx_sdata   = sd_q;
  assign link.rx_sstrobe = ss_q;
  assign link.rx_sframe  = sf_q;
  assign lna_en          = lna_q;
  assign mixer_en        = mix_q;
  assign bpf_en          = bpf_q;
  assign bpf_tuned       = tuned_q;
  assign cal_tone_en     = bpf_q && !tuned_q;
  assign tx_en           = st_q == RMS_TX;
  assign high_side_inj   = mode_q[0];
  assign power_down      = pd_q;
  assign radio_mode      = st_q;
  assign rx_bit_phase    = ph_q;
endmodule : rms_radio

/* File: tb/radio_mode_sequencer_tb_top.sv */
// bench: both ends joined by the link, software port and sample source driven here
// assumes package and interface compiled first; chain delays other than the filter enable shortened by parameters
`timescale 1ns/1ps
module radio_mode_sequencer_tb_top;
  import rms_pkg::*;
  localparam int TUNE_T = 500;
  localparam int ON_T   = 600;
  logic ref_clk, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, rd_q = 1'b0, sample_valid = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rd_val, rng = 32'd32368;
  logic [5:0]  sample_data = 6'h00, sample_out, last_smp = 6'h00;
  logic [3:0]  rssi_level = 4'h0;
  logic        sample_ready, lna_en, mixer_en, bpf_en, bpf_tuned, cal_tone_en, tx_en;
  logic        high_side_inj, power_down, sample_out_valid, cycle_on;
  logic [1:0]  rx_bit_phase;
  rms_mode_t   radio_mode;
  logic [5:0]  sq[$];
  logic [32:0] rq[$];
  int          fail_count = 0, checked = 0;
  rms_link_if rms_link_if_i ();
  rms_radio #(.LNA_ON_CYC(ON_T), .MIX_ON_CYC(ON_T), .BPF_TUNE_CYC(TUNE_T)) rms_radio_i (
    .ref_clk, .rst_n, .link(rms_link_if_i), .sample_data, .sample_valid, .sample_ready,
    .rssi_level, .lna_en, .mixer_en, .bpf_en, .bpf_tuned, .cal_tone_en, .tx_en,
    .high_side_inj, .power_down, .radio_mode, .rx_bit_phase);
  rms_baseband #(.TX_SETTLE_CYC(20)) rms_baseband_i (.ref_clk, .rst_n,
    .link(rms_link_if_i), .addr, .wdata, .wr, .rd, .rdata, .sample_out,
    .sample_out_valid, .cycle_on);
  rms_link_chk rms_link_chk_i (.ref_clk, .rst_n,
    .radio_cycle_enable_pin(rms_link_if_i.radio_cycle_enable_pin),
    .spi_clk(rms_link_if_i.spi_clk), .spi_cs_n(rms_link_if_i.spi_cs_n),
    .spi_mosi(rms_link_if_i.spi_mosi), .spi_miso(rms_link_if_i.spi_miso),
    .rx_sdata(rms_link_if_i.rx_sdata), .rx_sstrobe(rms_link_if_i.rx_sstrobe),
    .rx_sframe(rms_link_if_i.rx_sframe));
  function automatic logic [31:0] xs(logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xs
  task automatic cmp(logic [31:0] got, logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic win(int v, int lo);
    checked++;
    if (v < lo || v > lo + 8) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, v, lo);
    end
  endtask : win
  task automatic give_verdict();
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  task automatic wr32(logic [7:0] a, logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask : wr32
  // note goes in first so the watcher finds it when the data land
  task automatic rd32(logic [7:0] a, logic [32:0] e);
    rq.push_back(e);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 rd_val = rdata;
  endtask : rd32
  task automatic spi(logic [23:0] c);
    wr32(HOST_SPI_CMD_OFS, {8'h00, c});
    do rd32(HOST_STATUS_OFS, 33'h0); while (rd_val[0] !== 1'b0);
  endtask : spi
  task automatic send(int n);
    for (int i = 0; i < n; i++) begin
      rng = xs(rng);
      sample_data <= rng[5:0];
      sample_valid <= 1'b1;
      do @(posedge ref_clk); while (sample_ready !== 1'b1);
      sq.push_back(sample_data);
      last_smp = sample_data;
    end
    sample_valid <= 1'b0;
  endtask : send
  task automatic chain();
    int t[4];
    logic [3:0] v;
    while (cycle_on !== 1'b1) @(posedge ref_clk);
    for (int i = 1; i < 700; i++) begin
      @(posedge ref_clk);
      #1 v = {mixer_en, lna_en, bpf_tuned, bpf_en};
      cmp(32'(cal_tone_en), 32'(bpf_en & !bpf_tuned));
      for (int k = 0; k < 4; k++) if (v[k] === 1'b1 && t[k] == 0) t[k] = i;
    end
    win(t[0], BPF_ON_CYC);
    win(t[1], TUNE_T);
    win(t[2], ON_T);
    win(t[3], ON_T);
  endtask : chain
  task automatic stop_cycle();
    logic pd = 1'b0;
    wr32(HOST_CTRL_OFS, 32'h4);
    repeat (10) @(posedge ref_clk) pd = pd | power_down;
    cmp(32'({lna_en, mixer_en, bpf_en, pd, radio_mode}), 32'h4);
  endtask : stop_cycle
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    rd_q <= rd;
    if (rd_q && rq.size() > 0) begin
      if (rq[0][32]) cmp(rdata, rq[0][31:0]);
      void'(rq.pop_front());
    end
    if (sample_out_valid === 1'b1) begin
      if (sq.size() == 0) cmp(32'(sample_out), 32'hff);
      else cmp(32'(sample_out), 32'(sq.pop_front()));
    end
  end
  initial begin
    #500000;
    fail_count++;
    give_verdict();
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    rng = xs(rng);
    rssi_level <= rng[3:0];
    spi(24'h040040);
    spi(24'h090100);
    wr32(HOST_CTRL_OFS, 32'h0001 | (32'd39 << 8));
    fork
      chain();
      send(13);
    join
    // strength is taken 1600 clocks after the first sample
    repeat (1700) @(posedge ref_clk);
    cmp(32'({high_side_inj, radio_mode}), 32'h5);
    // odd sample count so a stuck phase counter cannot pass
    cmp(32'(rx_bit_phase), 32'(13 % SAMPLES_PER_BIT));
    rd32(HOST_SAMPLE_OFS, {1'b1, 26'h0, last_smp});
    wr32(HOST_CTRL_OFS, 32'h1);
    rd32(HOST_STATUS_OFS, 33'h1_0000_000c);
    stop_cycle();
    cmp(32'(sq.size()), 32'h0);
    spi(24'h9d0000);
    rd32(HOST_SPI_RD_OFS, {29'h1000_0000, rssi_level});
    spi(24'h090000);
    spi(24'h9d0000);
    rd32(HOST_SPI_RD_OFS, 33'h1_0000_0000);
    wr32(HOST_CTRL_OFS, 32'h0003 | (32'd40 << 8));
    while (cycle_on !== 1'b1) @(posedge ref_clk);
    repeat (100) @(posedge ref_clk);
    cmp(32'({tx_en, lna_en, mixer_en, bpf_en, high_side_inj, sample_ready}), 32'h20);
    cmp(32'(radio_mode), 32'(RMS_TX));
    stop_cycle();
    wr32(HOST_STATUS_OFS, 32'h8);
    rd32(HOST_STATUS_OFS, 33'h1_0000_0006);
    // raw access inside the settle window must be refused
    wr32(HOST_SPI_CMD_OFS, 32'h009d0000);
    rd32(HOST_STATUS_OFS, 33'h1_0000_000e);
    repeat (30) @(posedge ref_clk);
    rd32(HOST_STATUS_OFS, 33'h1_0000_0008);
    repeat (4) @(posedge ref_clk);
    give_verdict();
  end
endmodule : radio_mode_sequencer_tb_top

/* File: tb/rms_link_chk.sv */
// wire-level checks on the link between the radio end and the baseband end
// assumes both ends share ref_clk and the interface signals arrive as plain inputs
`timescale 1ns/1ps
module rms_link_chk (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic radio_cycle_enable_pin,
  input wire logic spi_clk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  input wire logic spi_miso,
  input wire logic rx_sdata,
  input wire logic rx_sstrobe,
  input wire logic rx_sframe
);
  import rms_pkg::*;
  logic [4:0] clk_cnt_q;
  logic [2:0] bit_cnt_q;
  logic       sclk_q;
  wire        sclk_rise = spi_clk & !sclk_q;
  always_ff @(posedge ref_clk) begin
    sclk_q <= spi_clk;
    clk_cnt_q <= (!rst_n || spi_cs_n) ? 5'h0 : clk_cnt_q + 5'(sclk_rise);
    bit_cnt_q <= !rst_n ? 3'h0 : rx_sframe ? 3'h1 : bit_cnt_q + 3'(rx_sstrobe);
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_frame_end;
    $rose(spi_cs_n);
  endsequence
  sequence s_cycle_start;
    $rose(radio_cycle_enable_pin);
  endsequence
  a_spi_clk_idle: assert property (spi_cs_n |-> !spi_clk)
    else $error("serial clock moved outside a frame");
  a_frame_len: assert property (s_frame_end |-> clk_cnt_q == 5'(SPI_FRAME_BITS))
    else $error("serial frame with wrong bit count");
  a_mosi_on_low: assert property (!spi_cs_n && $changed(spi_mosi) |-> !spi_clk)
    else $error("mosi changed while serial clock high");
  a_quiet_in_cycle: assert property (radio_cycle_enable_pin |-> spi_cs_n)
    else $error("serial access during a cycle");
  a_start_after_frame: assert property (s_cycle_start |-> spi_cs_n && $past(spi_cs_n))
    else $error("cycle enable rose during a mode write");
  a_frame_strobe: assert property (rx_sframe |-> rx_sstrobe)
    else $error("sample frame pulse without bit strobe");
  a_sample_len: assert property (rx_sframe && bit_cnt_q != 3'h0 |-> bit_cnt_q == 3'h6)
    else $error("sample not six bits long");
  a_sample_bits: assert property (rx_sstrobe && !rx_sframe |-> bit_cnt_q inside {[1:5]})
    else $error("bit strobe outside a sample");
  a_strobe_pace: assert property (rx_sstrobe [*2] |=> !rx_sstrobe)
    else $error("bit strobes faster than the serial rate");
endmodule : rms_link_chk
